// *** bench/pmd_operator.sv ***
// panel monitor display: operator at the keys, one press per command
// assumes go is raised only while busy is low; gap after release lets the panel settle
`timescale 1ns/100ps
module pmd_operator
    import pmd_pkg::*;
(
    input wire logic clk,
    input wire logic sysRst,
    input wire logic go,
    input wire logic [1:0] keySel,
    input wire logic [7:0] pressLen,
    output logic [KEY_N-1:0] keyPins,
    output logic busy
);
    logic [7:0] cnt;
    // keys are held stable for pressLen cycles, at least 4 in this bench, since the panel has no debounce
    always_ff @(posedge clk) begin
        if (sysRst) begin
            cnt <= 8'h00;
            keyPins <= '0;
        end else if (go && cnt == 8'h00) begin
            cnt <= pressLen + 8'h0c;
            keyPins <= 4'h1 << keySel;
        end else if (cnt != 8'h00) begin
            cnt <= cnt - 8'h01;
            if (cnt == 8'h0d) begin
                keyPins <= '0;
            end
        end
    end
    assign busy = (cnt != 8'h00);
endmodule

// *** bench/pmd_panel_tb_top.sv ***
// panel monitor display: self-checking bench with bus master and operator model
// assumes a shortened hold time; hready is looped back from hreadyout
`timescale 1ns/100ps
module pmd_panel_tb_top;
    import pmd_pkg::*;
    localparam int unsigned HOLD = 16;
    logic clk, sysRst, hsel, hwrite, hreadyout, hresp, go;
    logic [31:0] haddr, hwdata, hrdata, rd, val;
    logic [1:0] htrans, keySel, panelMode, shownItem, shownPage;
    logic [7:0] pressLen, ins, upperHalf, lowerHalf;
    logic [3:0] outs, keyPins;
    logic [15:0] segmentDigit;
    logic busy;
    int mismatches = 0, checks = 0, cycles = 0;
    pmd_operator op (.clk(clk), .sysRst(sysRst), .go(go), .keySel(keySel), .pressLen(pressLen),
        .keyPins(keyPins), .busy(busy));
    pmd_panel #(.HOLD_LEN(HOLD)) dut (.clk(clk), .sys_rst(sysRst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .menuSelectKey(keyPins[KEY_MENU]), .upKey(keyPins[KEY_UP]), .downKey(keyPins[KEY_DOWN]),
        .shiftKey(keyPins[KEY_SHIFT]), .servoOnInput(ins[0]), .proportionalCtrlInput(ins[1]),
        .forwardOvertravelInput(ins[2]), .reverseOvertravelInput(ins[3]), .alarmClearInput(ins[4]),
        .forwardTorqueLimitInput(ins[5]), .reverseTorqueLimitInput(ins[6]), .encoderSenseInput(ins[7]),
        .alarmOutput(outs[0]), .inPositionOutput(outs[1]), .rotationDetectOutput(outs[2]),
        .servoReadyOutput(outs[3]), .panelMode(panelMode), .shownItem(shownItem),
        .segmentDigit(segmentDigit), .shownPage(shownPage), .upperHalf(upperHalf), .lowerHalf(lowerHalf));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic final_report();
        $display("checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // ceiling well above the roughly 1300 cycles the sequence needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            final_report();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function automatic logic [15:0] bcd4(input logic [31:0] v);
        logic [15:0] r;
        r = '0;
        for (int i = 0; i < 4; i++) begin
            r[4*i +: 4] = 4'((v / (10 ** i)) % 10);
        end
        return r;
    endfunction
    function automatic logic [15:0] pageDigits(input logic [31:0] v, input int pg);
        case (pg)
            0: return bcd4(v % 10000);
            1: return bcd4((v / 10000) % 10000);
            default: return bcd4(v / 100000000);
        endcase
    endfunction
    // address phase held until hready, then data phase until hready again
    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= HTRANS_NONSEQ;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task automatic press(input int k, input int len);
        keySel <= 2'(k);
        pressLen <= 8'(len);
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        @(posedge clk);
        while (busy) @(posedge clk);
    endtask
    task automatic goItem(input int it);
        for (int i = 0; i < 4 && shownItem !== 2'(it); i++) begin
            press(KEY_UP, 4);
        end
    endtask
    initial begin
        {hsel, hwrite, go, haddr, hwdata, htrans, keySel, pressLen, ins, outs} = '0;
        sysRst = 1'b1;
        void'($urandom(32'h962034af));
        repeat (2) @(posedge clk);
        sysRst <= 1'b0;
        repeat (3) @(posedge clk);
        chk(panelMode, 0);
        chk(hreadyout, 1);
        press(KEY_MENU, 4);
        chk(panelMode, 1);
        press(KEY_UP, 4);
        chk(shownItem, 1);
        press(KEY_DOWN, 4);
        chk(shownItem, 0);
        press(KEY_DOWN, 4);
        chk(shownItem, 3);
        for (int it = 0; it < 2; it++) begin
            for (int rep = 0; rep < 2; rep++) begin
                // corner values: zero and the widest decimal number
                val = (rep == 0) ? $urandom : ((it == 0) ? 32'h0 : 32'hffffffff);
                ahb(1'b1, 32'(it * 4), val, rd);
                ahb(1'b0, 32'(it * 4), 32'h0, rd);
                chk(rd, val);
                goItem(it);
                press(KEY_SHIFT, HOLD + 8);
                chk({panelMode, shownPage}, {2'h2, 2'h0});
                repeat (80) @(posedge clk);
                chk(segmentDigit, pageDigits(val, 0));
                for (int p = 1; p < 4; p++) begin
                    press(KEY_SHIFT, 4);
                    chk({shownPage, segmentDigit}, {2'(p % 3), pageDigits(val, p % 3)});
                end
                press(KEY_SHIFT, 4);
                press(KEY_SHIFT, HOLD + 8);
                chk({panelMode, shownItem}, {2'h1, 2'(it)});
            end
        end
        for (int it = 2; it < 4; it++) begin
            goItem(it);
            press(KEY_SHIFT, HOLD + 8);
            chk(panelMode, 2);
            for (int rep = 0; rep < 3; rep++) begin
                ins <= (rep == 0) ? 8'hff : 8'($urandom);
                outs <= (rep == 0) ? 4'hf : 4'($urandom);
                repeat (8) @(posedge clk);
                if (it == 2) begin
                    chk({upperHalf, lowerHalf}, {~ins, ins});
                end else begin
                    chk({upperHalf, lowerHalf}, {4'h0, ~outs, 4'h0, outs});
                end
                ahb(1'b0, 32'h0c, 32'h0, rd);
                chk(rd, {20'h0, outs, ins});
            end
            ahb(1'b0, 32'h08, 32'h0, rd);
            chk(rd[3:0], {2'(it), 2'h2});
            press(KEY_SHIFT, HOLD + 8);
            chk({panelMode, shownItem}, {2'h1, 2'(it)});
        end
        // menu from a shown value goes back to selection and blanks the display
        press(KEY_SHIFT, HOLD + 8);
        press(KEY_MENU, 4);
        chk({panelMode, shownItem}, {2'h1, 2'h3});
        chk({upperHalf, lowerHalf, segmentDigit}, 32'h0);
        ahb(1'b1, 32'h08, 32'hffffffff, rd);
        ahb(1'b0, 32'h08, 32'h0, rd);
        chk(rd[5:0], {2'h0, 2'h3, 2'h1});
        ahb(1'b0, 32'h10, 32'h0, rd);
        chk(rd, 32'h0);
        chk(hresp, 0);
        final_report();
    end
endmodule

// *** hdl/pmd_bcd_conv.sv ***
// panel monitor display: serial binary to decimal converter, one bit per clock
// assumes start is only raised while busy is low
`timescale 1ns/100ps
module pmd_bcd_conv
    import pmd_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    pmd_bcd_if.conv cv
);
    typedef struct packed {
        logic busy;
        logic done;
        logic [5:0] count;
        logic [VALUE_W-1:0] bin;
        logic [BCD_W-1:0] work;
        logic [BCD_W-1:0] bcd;
    } pmd_conv_s;

    localparam logic [5:0] LAST_BIT = 6'(VALUE_W - 1);
    localparam logic [3:0] DIGIT_FIX = 4'h5;
    localparam logic [3:0] DIGIT_ADD = 4'h3;

    pmd_conv_s st;
    pmd_conv_s next_st;
    logic [BCD_W-1:0] adj;

    // shift-and-add-3: 32 cycles trades speed for a tiny area
    always_comb begin
        next_st = st;
        next_st.done = 1'b0;
        adj = st.work;
        for (int d = 0; d < BCD_DIGITS; d++) begin
            if (st.work[4*d +: 4] >= DIGIT_FIX) begin
                adj[4*d +: 4] = st.work[4*d +: 4] + DIGIT_ADD;
            end
        end
        if (!st.busy) begin
            if (cv.start) begin
                next_st.busy = 1'b1;
                next_st.bin = cv.bin;
                next_st.work = '0;
                next_st.count = '0;
            end
        end else begin
            next_st.work = {adj[BCD_W-2:0], st.bin[VALUE_W-1]};
            next_st.bin = {st.bin[VALUE_W-2:0], 1'b0};
            next_st.count = st.count + 6'h01;
            if (st.count == LAST_BIT) begin
                next_st.busy = 1'b0;
                next_st.done = 1'b1;
                next_st.bcd = {adj[BCD_W-2:0], st.bin[VALUE_W-1]};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign cv.busy = st.busy;
    assign cv.done = st.done;
    assign cv.bcd = st.bcd;

    generate
        for (genvar g = 0; g < BCD_DIGITS; g++) begin : g_dig
            chk_digit_decimal: assert property (@(posedge clk) disable iff (sys_rst)
                st.done |-> st.bcd[4*g +: 4] <= 4'h9)
                else $error("converted digit is not decimal");
        end
    endgenerate
endmodule

// *** hdl/pmd_bcd_if.sv ***
// panel monitor display: link between the panel and its decimal converter
// assumes both ends share one clock
`timescale 1ns/100ps
interface pmd_bcd_if;
    import pmd_pkg::*;
    logic start;
    logic [VALUE_W-1:0] bin;
    logic busy;
    logic done;
    logic [BCD_W-1:0] bcd;
    modport panel (output start, output bin, input busy, input done, input bcd);
    modport conv (input start, input bin, output busy, output done, output bcd);
endinterface

// *** hdl/pmd_panel.sv ***
// panel monitor display: key handling, item selection, paged decimal values
// and signal-state segment halves, with an AHB-Lite register slave
// assumes active-high raw key and signal pins, asynchronous to clk
//
// Our own choices: the AHB-Lite slave port and the address map.
`timescale 1ns/100ps
module pmd_panel
    import pmd_pkg::*;
#(
    parameter int unsigned HOLD_LEN = HOLD_CYCLES
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic menuSelectKey,
    input wire logic upKey,
    input wire logic downKey,
    input wire logic shiftKey,
    input wire logic servoOnInput,
    input wire logic proportionalCtrlInput,
    input wire logic forwardOvertravelInput,
    input wire logic reverseOvertravelInput,
    input wire logic alarmClearInput,
    input wire logic forwardTorqueLimitInput,
    input wire logic reverseTorqueLimitInput,
    input wire logic encoderSenseInput,
    input wire logic alarmOutput,
    input wire logic inPositionOutput,
    input wire logic rotationDetectOutput,
    input wire logic servoReadyOutput,
    output logic [1:0] panelMode,
    output logic [1:0] shownItem,
    output logic [15:0] segmentDigit,
    output logic [1:0] shownPage,
    output logic [7:0] upperHalf,
    output logic [7:0] lowerHalf
);
    localparam int unsigned HCW = $clog2(HOLD_LEN + 1);
    localparam logic [HCW-1:0] HOLD_LAST = HCW'(HOLD_LEN - 1);

    typedef struct packed {
        logic [KEY_N-1:0] keyMeta;
        logic [KEY_N-1:0] keySync;
        logic [KEY_N-1:0] keyLast;
        logic [SIG_N-1:0] inMeta;
        logic [SIG_N-1:0] inSync;
        logic [OUT_SIG_N-1:0] outMeta;
        logic [OUT_SIG_N-1:0] outSync;
        pmd_mode_e mode;
        pmd_page_e page;
        pmd_item_e item;
        logic [HCW-1:0] holdCnt;
        logic holdDone;
        logic [VALUE_W-1:0] speedValue;
        logic [VALUE_W-1:0] feedbackValue;
        logic [BCD_W-1:0] bcdValue;
        logic convStart;
        logic [VALUE_W-1:0] convBin;
        logic dValid;
        logic dWrite;
        logic [7:0] dAddr;
        logic [31:0] rdata;
        logic readyOut;
        logic [15:0] digits;
        logic [7:0] upper;
        logic [7:0] lower;
    } pmd_state_s;

    pmd_state_s st;
    pmd_state_s next_st;
    pmd_bcd_if bcdLink();

    logic menuPress;
    logic upPress;
    logic downPress;
    logic holdEv;
    logic shortEv;
    logic [SIG_N-1:0] inPins;
    logic [OUT_SIG_N-1:0] outPins;

    // register read view, used at the address phase
    function automatic logic [31:0] regRead(input logic [7:0] a, input pmd_state_s s);
        logic [31:0] r;
        r = '0;
        case (a)
            REG_SPEED_VALUE: r = s.speedValue;
            REG_FEEDBACK_VALUE: r = s.feedbackValue;
            REG_PANEL_STATUS: r = {24'h0, s.holdDone, 1'b0, s.page, s.item, s.mode};
            REG_SIGNAL_STATE: r = {20'h0, s.outSync, s.inSync};
            default: r = '0;
        endcase
        return r;
    endfunction

    // position 1 is bit 0
    assign inPins = {encoderSenseInput, reverseTorqueLimitInput, forwardTorqueLimitInput,
        alarmClearInput, reverseOvertravelInput, forwardOvertravelInput, proportionalCtrlInput, servoOnInput};
    assign outPins = {servoReadyOutput, rotationDetectOutput, inPositionOutput, alarmOutput};

    // edges read only the second sync stage and its delayed copy
    assign menuPress = st.keySync[KEY_MENU] & ~st.keyLast[KEY_MENU];
    assign upPress = st.keySync[KEY_UP] & ~st.keyLast[KEY_UP];
    assign downPress = st.keySync[KEY_DOWN] & ~st.keyLast[KEY_DOWN];
    assign holdEv = st.keySync[KEY_SHIFT] & ~st.holdDone & (st.holdCnt == HOLD_LAST);
    assign shortEv = ~st.keySync[KEY_SHIFT] & st.keyLast[KEY_SHIFT] & ~st.holdDone;

    always_comb begin
        next_st = st;
        next_st.keyMeta = {shiftKey, downKey, upKey, menuSelectKey};
        next_st.keySync = st.keyMeta;
        next_st.keyLast = st.keySync;
        next_st.inMeta = inPins;
        next_st.inSync = st.inMeta;
        next_st.outMeta = outPins;
        next_st.outSync = st.outMeta;
        next_st.readyOut = 1'b1;
        next_st.convStart = 1'b0;

        // hold timer fires once per press; release clears it
        if (!st.keySync[KEY_SHIFT]) begin
            next_st.holdCnt = '0;
            next_st.holdDone = 1'b0;
        end else if (!st.holdDone) begin
            if (holdEv) begin
                next_st.holdDone = 1'b1;
            end else begin
                next_st.holdCnt = st.holdCnt + HCW'(1);
            end
        end

        // panel sequence; in value mode menu wins over the shift key in the same cycle; item selection ignores menu
        case (st.mode)
            PANEL_OFF: begin
                if (menuPress) begin
                    next_st.mode = PANEL_ITEM;
                end
            end
            PANEL_ITEM: begin
                if (holdEv) begin
                    next_st.mode = PANEL_VALUE;
                    next_st.page = PAGE_LOW;
                end else if (upPress && !downPress) begin
                    next_st.item = pmd_item_e'(st.item + 2'h1);
                end else if (downPress && !upPress) begin
                    next_st.item = pmd_item_e'(st.item - 2'h1);
                end
            end
            PANEL_VALUE: begin
                if (menuPress) begin
                    next_st.mode = PANEL_ITEM;
                end else if (holdEv) begin
                    next_st.mode = PANEL_ITEM;
                end else if (shortEv && st.item < INPUT_STATE_ITEM) begin
                    case (st.page)
                        PAGE_LOW: next_st.page = PAGE_MID;
                        PAGE_MID: next_st.page = PAGE_TOP;
                        default: next_st.page = PAGE_LOW;
                    endcase
                end
            end
            default: next_st.mode = PANEL_OFF;
        endcase

        // keep the decimal copy fresh; a stale value lasts at most two conversions
        if (!bcdLink.busy && !st.convStart) begin
            next_st.convStart = 1'b1;
            next_st.convBin = (st.item == FEEDBACK_COUNT_ITEM) ? st.feedbackValue : st.speedValue;
        end
        if (bcdLink.done) begin
            next_st.bcdValue = bcdLink.bcd;
        end

        // display drive
        next_st.digits = '0;
        next_st.upper = '0;
        next_st.lower = '0;
        if (st.mode == PANEL_VALUE) begin
            case (st.item)
                INPUT_STATE_ITEM: begin
                    next_st.upper = ~st.inSync;
                    next_st.lower = st.inSync;
                end
                OUTPUT_STATE_ITEM: begin
                    next_st.upper = {4'h0, ~st.outSync};
                    next_st.lower = {4'h0, st.outSync};
                end
                default: begin
                    case (st.page)
                        PAGE_LOW: next_st.digits = st.bcdValue[15:0];
                        PAGE_MID: next_st.digits = st.bcdValue[31:16];
                        default: next_st.digits = {8'h0, st.bcdValue[39:32]};
                    endcase
                end
            endcase
        end

        // ahb-lite slave, zero wait states, always OKAY
        if (st.dValid && st.dWrite) begin
            case (st.dAddr)
                REG_SPEED_VALUE: next_st.speedValue = hwdata;
                REG_FEEDBACK_VALUE: next_st.feedbackValue = hwdata;
                default: next_st.speedValue = st.speedValue;
            endcase
        end
        next_st.dValid = 1'b0;
        next_st.dWrite = 1'b0;
        if (hsel && hready && htrans == HTRANS_NONSEQ) begin
            next_st.dValid = 1'b1;
            next_st.dWrite = hwrite;
            next_st.dAddr = haddr[7:0];
            next_st.rdata = hwrite ? 32'h0 : regRead(haddr[7:0], st);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign bcdLink.start = st.convStart;
    assign bcdLink.bin = st.convBin;

    pmd_bcd_conv u_conv (
        .clk(clk),
        .sys_rst(sys_rst),
        .cv(bcdLink.conv)
    );

    assign hreadyout = st.readyOut;
    assign hrdata = st.rdata;
    assign hresp = 1'b0;
    assign panelMode = st.mode;
    assign shownItem = st.item;
    assign shownPage = st.page;
    assign segmentDigit = st.digits;
    assign upperHalf = st.upper;
    assign lowerHalf = st.lower;

    chk_menu_enters_item: assert property (@(posedge clk) disable iff (sys_rst)
        (menuPress && st.mode != PANEL_ITEM) |=> st.mode == PANEL_ITEM)
        else $error("menu press did not enter item selection");
    chk_item_steps_up: assert property (@(posedge clk) disable iff (sys_rst)
        (st.mode == PANEL_ITEM && !holdEv && upPress && !downPress) |=> st.item == 2'($past(st.item) + 2'h1))
        else $error("up key did not step item");
    chk_item_steps_down: assert property (@(posedge clk) disable iff (sys_rst)
        (st.mode == PANEL_ITEM && !holdEv && downPress && !upPress) |=> st.item == 2'($past(st.item) - 2'h1))
        else $error("down key did not step item");
    chk_hold_enters_value: assert property (@(posedge clk) disable iff (sys_rst)
        (st.mode == PANEL_ITEM && holdEv) |=> (st.mode == PANEL_VALUE && st.page == PAGE_LOW))
        else $error("hold did not open value on lowest page");
    chk_hold_leaves_value: assert property (@(posedge clk) disable iff (sys_rst)
        (st.mode == PANEL_VALUE && holdEv) |=> (st.mode == PANEL_ITEM && $stable(st.item)))
        else $error("hold did not return to item number");
    chk_page_cycle: assert property (@(posedge clk) disable iff (sys_rst)
        (st.mode == PANEL_VALUE && !menuPress && st.item < INPUT_STATE_ITEM && shortEv && st.page == PAGE_TOP)
        |=> st.page == PAGE_LOW ##1 st.page == PAGE_LOW)
        else $error("top page did not wrap to lowest");
    chk_page_advance: assert property (@(posedge clk) disable iff (sys_rst)
        (st.mode == PANEL_VALUE && !menuPress && st.item < INPUT_STATE_ITEM && shortEv && st.page == PAGE_LOW)
        |=> st.page == PAGE_MID)
        else $error("short press did not reach middle page");
    chk_input_halves: assert property (@(posedge clk) disable iff (sys_rst)
        (st.mode == PANEL_VALUE && st.item == INPUT_STATE_ITEM) |=> (lowerHalf == $past(st.inSync)
        && upperHalf == ~lowerHalf))
        else $error("input halves wrong");
    chk_output_reserved: assert property (@(posedge clk) disable iff (sys_rst)
        (st.mode == PANEL_VALUE && st.item == OUTPUT_STATE_ITEM) |=> (upperHalf[7:4] == 4'h0
        && lowerHalf[7:4] == 4'h0 && lowerHalf[3:0] == $past(st.outSync)
        && upperHalf[3:0] == ~lowerHalf[3:0]))
        else $error("output positions wrong");
    chk_press_once: assert property (@(posedge clk) disable iff (sys_rst)
        holdEv |=> (!holdEv && !shortEv) [*2])
        else $error("shift press acted twice");
endmodule

// *** hdl/pmd_pkg.sv ***
// panel monitor display: shared constants, enums and register map
// assumes a 20 MHz system clock and an AHB-Lite register bus with 32-bit data
package pmd_pkg;
    localparam int unsigned CLK_HZ = 20000000;
    localparam int unsigned HOLD_TIME_MS = 1000;
    localparam int unsigned HOLD_CYCLES = HOLD_TIME_MS * (CLK_HZ / 1000);
    localparam int unsigned VALUE_W = 32;
    localparam int unsigned BCD_DIGITS = 10;
    localparam int unsigned BCD_W = 4 * BCD_DIGITS;
    localparam int unsigned SIG_N = 8;
    localparam int unsigned OUT_SIG_N = 4;
    localparam int unsigned KEY_N = 4;
    // key bit positions
    localparam int unsigned KEY_MENU = 0;
    localparam int unsigned KEY_UP = 1;
    localparam int unsigned KEY_DOWN = 2;
    localparam int unsigned KEY_SHIFT = 3;
    // register byte offsets
    localparam logic [7:0] REG_SPEED_VALUE = 8'h00;
    localparam logic [7:0] REG_FEEDBACK_VALUE = 8'h04;
    localparam logic [7:0] REG_PANEL_STATUS = 8'h08;
    localparam logic [7:0] REG_SIGNAL_STATE = 8'h0c;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    // monitor items
    typedef enum logic [1:0] {
        MOTOR_SPEED_ITEM,
        FEEDBACK_COUNT_ITEM,
        INPUT_STATE_ITEM,
        OUTPUT_STATE_ITEM
    } pmd_item_e;
    typedef enum logic [1:0] {PANEL_OFF, PANEL_ITEM, PANEL_VALUE} pmd_mode_e;
    typedef enum logic [1:0] {PAGE_LOW, PAGE_MID, PAGE_TOP} pmd_page_e;
endpackage
